//--- dac_path_params.svh
// constants of the multichannel converter data path
`ifndef DAC_PATH_PARAMS_SVH
`define DAC_PATH_PARAMS_SVH
`define CHANNELS 40
`define GROUPS 5
`define GROUP_SIZE 8
`define CODE_BITS 16
`define LEVEL_BITS 14
`define WORD_BITS 24
`define WORD_LAST 5'h17
`define INPUT_RESET 16'h1555
`define GAIN_RESET 16'h3FFF
`define OFFSET_RESET 16'h2000
`define LEVEL_RESET 14'h1555
`define CONTROL_RESET 3'h0
`define SELECT_RESET 40'h00_0000_0000
`define CTRL_AB_BIT 2
`define CTRL_THERM_BIT 1
`define CTRL_PD_BIT 0
`define MODE_SPECIAL 2'h0
`define MODE_GAIN 2'h1
`define MODE_OFFSET 2'h2
`define MODE_DATA 2'h3
`define SP_CONTROL 6'h01
`define SP_LEVEL0 6'h02
`define SP_LEVEL1 6'h03
`define SP_SELECT0 6'h04
`define SP_SELECT4 6'h08
`define SP_GLOBAL_AB 6'h0B
`define MID_CODE 19'h0_8000
`define CODE_MAX 16'hFFFF
`endif

//--- dac_path_pkg.sv
// types shared by the converter data path
`default_nettype none
`include "dac_path_params.svh"
package dac_path_pkg;
    // one serial word: mode, address, payload
    typedef struct packed {
        logic [1:0] mode;
        logic [5:0] addr;
        logic [15:0] data;
    } serial_word_s;
    typedef enum logic [1:0] {
        CALC_IDLE = 2'b00,
        CALC_MUL = 2'b01,
        CALC_ADD = 2'b10
    } calc_state_e;
endpackage
`default_nettype wire

//--- dac_data_path.sv
// multichannel converter data path: serial intake, shared calibration engine, load
`timescale 1ns/1ps
`default_nettype none
`include "dac_path_params.svh"
module dac_data_path
    import dac_path_pkg::*;
(
    input wire logic clock_i, // system clock
    input wire logic reset_n_i, // async reset, active low
    input wire logic clk_en_i, // freezes system-domain state when low
    input wire logic serial_clk_i, // link clock from host
    input wire logic frame_sync_n_i, // frame select, active low
    input wire logic serial_data_i, // serial data in
    input wire logic load_strobe_n_i, // load pin, active low
    output logic [`CHANNELS*`CODE_BITS-1:0] dac_code_o, // final codes, channel 0 lowest
    output logic [`LEVEL_BITS-1:0] group0_offset_level_o, // group 0 offset level
    output logic [`LEVEL_BITS-1:0] group1to4_offset_level_o, // groups 1-4 offset level
    output logic thermal_shutdown_en_o, // thermal shutdown enable
    output logic power_down_o, // soft power-down
    output logic busy_o // recalculation pending or running
);
    // ---------------- link domain ----------------
    logic frame_idle;
    logic [4:0] bit_count;
    logic [`WORD_BITS-1:0] shift;
    logic [`WORD_BITS-1:0] held_word;
    logic word_toggle;

    assign frame_idle = frame_sync_n_i | ~reset_n_i;

    // frame end clears the shifter, no edge needed after the last bit
    always_ff @(negedge serial_clk_i or posedge frame_idle) begin
        if (frame_idle) begin
            bit_count <= 5'h00;
            shift <= 24'h00_0000;
        end else begin
            shift <= {shift[`WORD_BITS-2:0], serial_data_i};
            bit_count <= (bit_count == `WORD_LAST) ? 5'h00 : bit_count + 5'h01;
        end
    end

    // word held stable for the crossing; toggle marks it
    always_ff @(negedge serial_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            held_word <= 24'h00_0000;
            word_toggle <= 1'b0;
        end else if (!frame_sync_n_i && bit_count == `WORD_LAST) begin
            held_word <= {shift[`WORD_BITS-2:0], serial_data_i};
            word_toggle <= ~word_toggle;
        end
    end

    // ---------------- system domain ----------------
    logic toggle_meta;
    logic toggle_sync;
    logic toggle_seen;
    logic load_meta;
    logic load_sync_n;
    logic word_valid;
    logic load_active;
    serial_word_s word;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            toggle_meta <= 1'b0;
            toggle_sync <= 1'b0;
            toggle_seen <= 1'b0;
            load_meta <= 1'b1;
            load_sync_n <= 1'b1;
        end else if (clk_en_i) begin
            toggle_meta <= word_toggle;
            toggle_sync <= toggle_meta;
            toggle_seen <= toggle_sync;
            load_meta <= load_strobe_n_i;
            load_sync_n <= load_meta;
        end
    end

    assign word_valid = clk_en_i & (toggle_sync ^ toggle_seen);
    assign load_active = clk_en_i & ~load_sync_n;
    assign word = serial_word_s'(held_word);

    // register file
    logic [15:0] input_data_a [`CHANNELS];
    logic [15:0] input_data_b [`CHANNELS];
    logic [15:0] gain_trim [`CHANNELS];
    logic [15:0] offset_trim [`CHANNELS];
    logic [15:0] calibrated_data_a [`CHANNELS];
    logic [15:0] calibrated_data_b [`CHANNELS];
    logic [15:0] dac_code [`CHANNELS];
    logic [`LEVEL_BITS-1:0] group0_offset_level;
    logic [`LEVEL_BITS-1:0] group1to4_offset_level;
    logic [2:0] control;
    logic [`CHANNELS-1:0] source_select; // group g at bits 8g+7..8g

    logic is_chan;
    logic [5:0] chan;
    logic target_b;

    assign chan = word.addr;
    assign is_chan = word_valid && (word.mode != `MODE_SPECIAL) && (chan < 6'(`CHANNELS));
    assign target_b = control[`CTRL_AB_BIT];

    // per-channel storage, no per-channel A/B override
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < `CHANNELS; i++) begin
                input_data_a[i] <= `INPUT_RESET;
                input_data_b[i] <= `INPUT_RESET;
                gain_trim[i] <= `GAIN_RESET;
                offset_trim[i] <= `OFFSET_RESET;
            end
        end else if (is_chan) begin
            if (word.mode == `MODE_DATA && !target_b) begin
                input_data_a[chan] <= word.data;
            end else if (word.mode == `MODE_DATA) begin
                input_data_b[chan] <= word.data;
            end else if (word.mode == `MODE_GAIN) begin
                gain_trim[chan] <= word.data;
            end else begin
                offset_trim[chan] <= word.data;
            end
        end
    end

    // shared settings
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            control <= `CONTROL_RESET;
            group0_offset_level <= `LEVEL_RESET;
            group1to4_offset_level <= `LEVEL_RESET;
            source_select <= `SELECT_RESET;
        end else if (word_valid && word.mode == `MODE_SPECIAL) begin
            if (word.addr == `SP_CONTROL) begin
                control <= word.data[2:0];
            end else if (word.addr == `SP_LEVEL0) begin
                group0_offset_level <= word.data[`LEVEL_BITS-1:0];
            end else if (word.addr == `SP_LEVEL1) begin
                group1to4_offset_level <= word.data[`LEVEL_BITS-1:0];
            end else if (word.addr >= `SP_SELECT0 && word.addr <= `SP_SELECT4) begin
                source_select[(word.addr - `SP_SELECT0)*`GROUP_SIZE +: `GROUP_SIZE] <= word.data[7:0];
            end else if (word.addr == `SP_GLOBAL_AB) begin
                source_select <= {`CHANNELS{word.data[0]}};
            end
        end
    end

    assign thermal_shutdown_en_o = control[`CTRL_THERM_BIT];
    assign power_down_o = control[`CTRL_PD_BIT];
    assign group0_offset_level_o = group0_offset_level;
    assign group1to4_offset_level_o = group1to4_offset_level;

    // recalculation queue
    logic [`CHANNELS-1:0] pending_a;
    logic [`CHANNELS-1:0] pending_b;
    logic [`CHANNELS-1:0] set_a;
    logic [`CHANNELS-1:0] set_b;
    logic [`CHANNELS-1:0] clear_a;
    logic [`CHANNELS-1:0] clear_b;
    logic [2*`CHANNELS-1:0] pending_all;
    logic [6:0] pick;
    logic pick_any;
    calc_state_e calc_state;
    logic [5:0] job_chan;
    logic job_b;
    logic [32:0] product;
    logic signed [18:0] sum;
    logic [15:0] result;

    always_comb begin
        set_a = '0;
        set_b = '0;
        if (is_chan) begin
            set_a[chan] = ~target_b;
            set_b[chan] = target_b;
        end
    end

    assign pending_all = {pending_b, pending_a};

    // lowest waiting job, A side first
    always_comb begin
        pick = 7'h00;
        pick_any = 1'b0;
        for (int i = 2*`CHANNELS-1; i >= 0; i--) begin
            if (pending_all[i]) begin
                pick = 7'(i);
                pick_any = 1'b1;
            end
        end
    end

    always_comb begin
        clear_a = '0;
        clear_b = '0;
        if (calc_state == CALC_IDLE && pick_any) begin
            if (pick < 7'(`CHANNELS)) begin
                clear_a[pick[5:0]] = 1'b1;
            end else begin
                clear_b[6'(pick - 7'(`CHANNELS))] = 1'b1;
            end
        end
    end

    // set beats clear, so a write during its own job reruns it
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pending_a <= '0;
            pending_b <= '0;
        end else if (clk_en_i) begin
            pending_a <= (pending_a & ~clear_a) | set_a;
            pending_b <= (pending_b & ~clear_b) | set_b;
        end
    end

    // single engine, one channel at a time
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            calc_state <= CALC_IDLE;
            job_chan <= 6'h00;
            job_b <= 1'b0;
            product <= 33'h0_0000_0000;
        end else if (clk_en_i) begin
            case (calc_state)
                CALC_IDLE: begin
                    if (pick_any) begin
                        job_b <= (pick >= 7'(`CHANNELS));
                        job_chan <= (pick >= 7'(`CHANNELS)) ? 6'(pick - 7'(`CHANNELS)) : pick[5:0];
                        calc_state <= CALC_MUL;
                    end
                end
                CALC_MUL: begin
                    product <= (job_b ? input_data_b[job_chan] : input_data_a[job_chan])
                        * ({1'b0, gain_trim[job_chan]} + 17'h0_0001);
                    calc_state <= CALC_ADD;
                end
                CALC_ADD: begin
                    calc_state <= CALC_IDLE;
                end
                default: begin
                    calc_state <= CALC_IDLE;
                end
            endcase
        end
    end

    assign sum = $signed({2'b00, product[32:16]}) + $signed({3'b000, offset_trim[job_chan]})
        - $signed(`MID_CODE);
    assign result = (sum < 0) ? 16'h0000 : (sum > $signed({3'b000, `CODE_MAX})) ? `CODE_MAX : sum[15:0];

    // calibrated registers, written only by the engine
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < `CHANNELS; i++) begin
                calibrated_data_a[i] <= 16'h0000;
                calibrated_data_b[i] <= 16'h0000;
            end
        end else if (clk_en_i && calc_state == CALC_ADD) begin
            if (job_b) begin
                calibrated_data_b[job_chan] <= result;
            end else begin
                calibrated_data_a[job_chan] <= result;
            end
        end
    end

    assign busy_o = (calc_state != CALC_IDLE) | (|pending_a) | (|pending_b);

    // final codes change only while the synchronized load is low and the clock enable is high
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < `CHANNELS; i++) begin
                dac_code[i] <= 16'h0000;
            end
        end else if (load_active) begin
            for (int i = 0; i < `CHANNELS; i++) begin
                dac_code[i] <= source_select[i] ? calibrated_data_b[i] : calibrated_data_a[i];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < `CHANNELS; i++) begin
            dac_code_o[i*`CODE_BITS +: `CODE_BITS] = dac_code[i];
        end
    end

    // ---------------- assertions ----------------
    sequence s_job_start;
        calc_state == CALC_IDLE && pick_any && clk_en_i;
    endsequence
    sequence s_job_run;
        calc_state == CALC_MUL ##1 calc_state == CALC_ADD ##1 calc_state == CALC_IDLE;
    endsequence

    sequence s_pin_held_low;
        !load_strobe_n_i ##1 !load_strobe_n_i;
    endsequence
    sequence s_pin_held_high;
        load_strobe_n_i ##1 load_strobe_n_i;
    endsequence

    a_engine_steps: assert property (@(posedge clock_i) disable iff (!reset_n_i || !clk_en_i)
        s_job_start |=> s_job_run)
        else $error("engine did not run mul then add");
    a_final_only_load: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        dac_code[0] != $past(dac_code[0]) |-> $past(load_active))
        else $error("final code changed without load");
    a_load_picks_src: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        load_active |=> dac_code[9] == ($past(source_select[9]) ? $past(calibrated_data_b[9])
            : $past(calibrated_data_a[9])))
        else $error("load took the wrong source");
    a_write_queues: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        is_chan && word.mode == `MODE_DATA && !target_b |=> pending_a[$past(chan)]
            || (calc_state == CALC_MUL && !job_b && job_chan == $past(chan)))
        else $error("data write to A not queued");
    a_trim_side: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        is_chan && word.mode == `MODE_GAIN && target_b |=> pending_b[$past(chan)]
            || (calc_state == CALC_MUL && job_b))
        else $error("trim write with select 1 did not queue side B");
    a_no_lost_job: assert property (@(posedge clock_i) disable iff (!reset_n_i || !clk_en_i)
        pending_a[3] && !(calc_state == CALC_IDLE && pick == 7'h03) |=> pending_a[3])
        else $error("pending job dropped");
    a_queue_drains: assert property (@(posedge clock_i) disable iff (!reset_n_i || !clk_en_i)
        pending_b[39] && calc_state == CALC_IDLE
            |-> ##[0:240] (calc_state == CALC_MUL && job_b && job_chan == 6'h27))
        else $error("queued job not served in time");
    a_global_fill: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        word_valid && word.mode == `MODE_SPECIAL && word.addr == `SP_GLOBAL_AB
            |=> source_select == {`CHANNELS{$past(word.data[0])}})
        else $error("global select fill failed");
    a_ctrl_bits: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        word_valid && word.mode == `MODE_SPECIAL && word.addr == `SP_CONTROL
            |=> power_down_o == $past(word.data[0]) && thermal_shutdown_en_o == $past(word.data[1]))
        else $error("control bits not applied");
    a_cal_written: assert property (@(posedge clock_i) disable iff (!reset_n_i || !clk_en_i)
        calc_state == CALC_ADD && !job_b |=> calibrated_data_a[$past(job_chan)] == $past(result))
        else $error("calibrated A not stored");
    a_cal_b_written: assert property (@(posedge clock_i) disable iff (!reset_n_i || !clk_en_i)
        calc_state == CALC_ADD && job_b |=> calibrated_data_b[$past(job_chan)] == $past(result))
        else $error("calibrated B not stored");

    // channel and level writes land in the registers they address; writes past channel 39 queue nothing
    a_data_lands_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        is_chan && word.mode == `MODE_DATA && !target_b |=> input_data_a[$past(chan)] == $past(word.data))
        else $error("data write missed input register A");
    a_data_lands_b: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        is_chan && word.mode == `MODE_DATA && target_b |=> input_data_b[$past(chan)] == $past(word.data))
        else $error("data write missed input register B");
    a_gain_lands: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        is_chan && word.mode == `MODE_GAIN |=> gain_trim[$past(chan)] == $past(word.data))
        else $error("gain trim write lost");
    a_offset_lands: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        is_chan && word.mode == `MODE_OFFSET |=> offset_trim[$past(chan)] == $past(word.data))
        else $error("offset trim write lost");
    a_far_chan_ignored: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        word_valid && word.mode != `MODE_SPECIAL && word.addr >= 6'(`CHANNELS) |-> set_a == '0 && set_b == '0)
        else $error("write beyond last channel queued a job");
    a_level0_lands: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        word_valid && word.mode == `MODE_SPECIAL && word.addr == `SP_LEVEL0
            |=> group0_offset_level_o == $past(word.data[`LEVEL_BITS-1:0]))
        else $error("group 0 offset level not written");
    a_level1_lands: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        word_valid && word.mode == `MODE_SPECIAL && word.addr == `SP_LEVEL1
            |=> group1to4_offset_level_o == $past(word.data[`LEVEL_BITS-1:0]))
        else $error("group 1-4 offset level not written");

    // load pin path and freeze
    a_load_sync_lat: assert property (@(posedge clock_i) disable iff (!reset_n_i || !clk_en_i)
        s_pin_held_low |=> load_active)
        else $error("load pin not seen two edges later");
    a_pin_high_idle: assert property (@(posedge clock_i) disable iff (!reset_n_i || !clk_en_i)
        s_pin_held_high |=> !load_active)
        else $error("load active while pin high");
    a_load_idle_hold: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !load_active |=> dac_code[20] == $past(dac_code[20]))
        else $error("final code moved without load");
    a_freeze_holds: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !clk_en_i |=> calc_state == $past(calc_state) && pending_a == $past(pending_a)
            && pending_b == $past(pending_b) && toggle_sync == $past(toggle_sync))
        else $error("state moved while clock enable low");
endmodule
`default_nettype wire

//--- dac_host_model.sv
// host-side model: serial word sender and load pin driver
`timescale 1ns/1ps
`default_nettype none
module dac_host_model (
    input wire logic clock_i, // system clock
    output logic sclk_o, // link clock, idles high
    output logic sync_n_o, // frame select, active low
    output logic sdata_o, // serial data
    output logic load_n_o // load pin, active low
);
    logic [23:0] q[$];
    initial begin
        sclk_o = 1'b1;
        sync_n_o = 1'b1;
        sdata_o = 1'b0;
        load_n_o = 1'b1;
    end
    // queued words MSB first; fewer bits than 24 per word cuts the frame
    task automatic frame(input int nbits);
        int i;
        #3.7;
        sync_n_o = 1'b0;
        for (i = 0; i < nbits; i++) begin
            #1 sdata_o = q[i / 24][23 - i % 24];
            #15 sclk_o = 1'b0;
            #16 sclk_o = 1'b1;
        end
        #16 sync_n_o = 1'b1;
        sdata_o = ~sdata_o;
        q.delete();
    endtask
    task automatic load();
        @(posedge clock_i);
        #1 load_n_o = 1'b0;
        repeat (6) @(posedge clock_i);
        #1 load_n_o = 1'b1;
    endtask
endmodule
`default_nettype wire

//--- tb_multichannel_dac_data_path.sv
// self-checking bench for the converter data path
`timescale 1ns/1ps
`default_nettype none
module tb_multichannel_dac_data_path;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic sclk, sync_n, sdata, load_n, tsd_en, pd, busy;
    logic [639:0] codes;
    logic [13:0] lvl0, lvl1, m_lv0, m_lv1;
    int error_cnt = 0;
    int n_checks = 0;
    logic [15:0] in_m[2][40];
    logic [15:0] gn[40], ofs[40], cal[2][40], fin[40];
    logic [2:0] ctl;
    logic [39:0] sel;
    always #5 clock_i = ~clock_i;
    dac_host_model host_u (.clock_i(clock_i), .sclk_o(sclk), .sync_n_o(sync_n), .sdata_o(sdata),
        .load_n_o(load_n));
    dac_data_path dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
        .serial_clk_i(sclk), .frame_sync_n_i(sync_n), .serial_data_i(sdata), .load_strobe_n_i(load_n),
        .dac_code_o(codes), .group0_offset_level_o(lvl0), .group1to4_offset_level_o(lvl1),
        .thermal_shutdown_en_o(tsd_en), .power_down_o(pd), .busy_o(busy));
    function automatic logic [15:0] calc(input logic [15:0] x, input logic [15:0] g, input logic [15:0] o);
        logic [33:0] t;
        t = ((34'(x) * (34'(g) + 34'h1)) >> 16) + 34'(o);
        if (t < 34'h0_8000) return 16'h0000;
        if (t > 34'h1_7FFF) return 16'hFFFF;
        return 16'(t - 34'h0_8000);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask
    // queues one word and updates the expected state in the same order
    task automatic wr(input logic [1:0] m, input logic [5:0] a, input logic [15:0] d);
        logic s;
        s = ctl[2];
        host_u.q.push_back({m, a, d});
        if (m == 2'h0) begin
            if (a == 6'h01) ctl = d[2:0];
            if (a == 6'h02) m_lv0 = d[13:0];
            if (a == 6'h03) m_lv1 = d[13:0];
            if (a == 6'h0B) sel = {40{d[0]}};
            if (a >= 6'h04 && a <= 6'h08) sel[(a - 6'h04) * 8 +: 8] = d[7:0];
        end else if (a < 6'h28) begin
            if (m == 2'h3) in_m[s][a] = d;
            if (m == 2'h1) gn[a] = d;
            if (m == 2'h2) ofs[a] = d;
            cal[s][a] = calc(in_m[s][a], gn[a], ofs[a]);
        end
    endtask
    task automatic go();
        int k;
        if (host_u.q.size() > 0) host_u.frame(24 * host_u.q.size());
        repeat (10) @(posedge clock_i);
        k = 0;
        while (busy !== 1'b0 && k < 1000) begin
            @(posedge clock_i);
            k++;
        end
        if (k == 1000) begin
            error_cnt++;
            $display("ERROR t=%0t busy=%h exp=%h", $time, busy, 1'b0);
            summarize();
        end
        #1;
    endtask
    task automatic codes_chk();
        for (int i = 0; i < 40; i++) chk(codes[i * 16 +: 16], fin[i]);
    endtask
    task automatic load_chk();
        host_u.load();
        for (int i = 0; i < 40; i++) fin[i] = sel[i] ? cal[1][i] : cal[0][i];
        codes_chk();
    endtask
    task automatic regs_chk();
        chk(16'(lvl0), 16'(m_lv0));
        chk(16'(lvl1), 16'(m_lv1));
        chk(16'(tsd_en), 16'(ctl[1]));
        chk(16'(pd), 16'(ctl[0]));
    endtask
    initial begin
        for (int i = 0; i < 40; i++) begin
            in_m[0][i] = 16'h1555;
            in_m[1][i] = 16'h1555;
            gn[i] = 16'h3FFF;
            ofs[i] = 16'h2000;
            cal[0][i] = 16'h0000;
            cal[1][i] = 16'h0000;
            fin[i] = 16'h0000;
        end
        ctl = 3'h0;
        sel = 40'h00_0000_0000;
        m_lv0 = 14'h1555;
        m_lv1 = 14'h1555;
        repeat (8) @(posedge clock_i);
        #1 reset_n_i = 1'b1;
        regs_chk();
        codes_chk();
        chk(16'(busy), 16'h0000);
        done("reset");
        wr(2'h0, 6'h01, 16'h0003);
        wr(2'h0, 6'h02, 16'h3ABC);
        wr(2'h0, 6'h03, 16'h0123);
        go();
        regs_chk();
        done("control");
        wr(2'h2, 6'h05, 16'hC000);
        wr(2'h1, 6'h06, 16'hFFFF);
        wr(2'h3, 6'h06, 16'hFFFF);
        go();
        codes_chk();
        load_chk();
        done("trim");
        for (int s = 0; s < 2; s++) begin
            wr(2'h0, 6'h01, 16'(s * 4));
            for (int i = 0; i < 40; i++) begin
                if (s == 0) wr(2'h1, 6'(i), 16'hFFFF);
                if (s == 0) wr(2'h2, 6'(i), 16'h8000);
                wr(2'h3, 6'(i), 16'(i * 1637 + s * 777));
            end
            wr(2'h3, 6'h28, 16'hFFFF);
            wr(2'h1, 6'h03, 16'h7FFF);
            go();
        end
        load_chk();
        wr(2'h0, 6'h0B, 16'h0001);
        go();
        load_chk();
        wr(2'h0, 6'h0B, 16'h0000);
        wr(2'h0, 6'h06, 16'h00A5);
        wr(2'h0, 6'h08, 16'h003C);
        wr(2'h0, 6'h01, 16'h0000);
        go();
        load_chk();
        done("select");
        // one word sent while frozen must wait for the enable
        @(posedge clock_i);
        #1 clk_en_i = 1'b0;
        wr(2'h0, 6'h01, 16'h0002);
        host_u.frame(24);
        repeat (10) @(posedge clock_i);
        #1 chk(16'(tsd_en), 16'h0000);
        chk(16'(busy), 16'h0000);
        clk_en_i = 1'b1;
        go();
        regs_chk();
        done("freeze");
        host_u.q.push_back(24'hC3_4321);
        host_u.frame(13);
        go();
        load_chk();
        done("partial");
        summarize();
    end
    initial begin
        #1_000_000;
        error_cnt++;
        $display("ERROR t=%0t watchdog expired", $time);
        summarize();
    end
endmodule
`default_nettype wire
